/* File: pkg/pecf_pkg.sv */
// pecf_pkg: constants for the performance event counter and filter block.
// assumes a single core clock domain and a model-specific register access port.
`default_nettype none
package pecf_pkg;
    localparam int          NUM_CTR        = 8;
    localparam int          CTR_W          = 48;
    localparam int          MSR_AW         = 32;
    localparam int          IP_W           = 48;
    // register map
    localparam logic [31:0] EVTSEL_BASE    = 32'h0000_0186;
    localparam logic [31:0] EVTSEL_LAST    = 32'h0000_018D;
    localparam logic [31:0] CTR_BASE       = 32'h0000_00C1;
    localparam logic [31:0] CTR_LAST       = 32'h0000_00C8;
    localparam logic [31:0] UNC_CFG_ADDR   = 32'h0000_0396;
    localparam logic [31:0] UNC_MON_BASE   = 32'h0000_0700;
    localparam logic [31:0] UNC_MON_LAST   = 32'h0000_07FF;
    localparam int          UNC_STRIDE_LSB = 4;
    localparam logic [3:0]  UNC_UNITS_DEF  = 4'h4;
    // event select fields
    localparam int          SEL_EVT_LSB    = 0;
    localparam int          SEL_UMASK_LSB  = 8;
    localparam int          SEL_USR_BIT    = 16;
    localparam int          SEL_OS_BIT     = 17;
    localparam int          SEL_EN_BIT     = 22;
    localparam int          SEL_INV_BIT    = 23;
    localparam int          SEL_COUNT_THRESHOLD_LSB  = 24;
    localparam logic [63:0] SEL_RESET      = 64'h0000_0000_0000_0000;
    // decoded event encodings
    localparam logic [7:0]  EVT_LOAD_RET   = 8'hD1;
    localparam logic [7:0]  UM_LLC_HIT     = 8'h40;
    localparam logic [7:0]  UM_LLC_MISS    = 8'h20;
    localparam logic [7:0]  UM_L2_HIT      = 8'h02;
    localparam logic [7:0]  EVT_DEMAND_OUT = 8'h60;
    localparam logic [7:0]  EVT_DEMAND_REQ = 8'hB0;
    localparam logic [7:0]  UM_DEMAND      = 8'h01;
endpackage
`default_nettype wire

/* File: core/pecf_counter_filter.sv */
// pecf_counter_filter: eight filtered event counters, register port,
// uncore fault check and branch record source selection.
// assumes pipeline event inputs and register requests are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

// Function
// - eight counters, each counts its selected event
// - kernel bit 17, user bit 16 filters
// - invert with threshold counts cycles below threshold
// - missing uncore monitor register raises fault
// - no call record for zero-length calls
// - llc load hit D1/40, miss D1/20
// - D1/02 counts locked second-level hits too
// - demand events exclude next-page prefetcher requests
// - abort record holds abort source pointer
module pecf_counter_filter (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         resetn,
    // register access port
    input  wire logic                         msrReq,
    input  wire logic                         msrWrite,
    input  wire logic [pecf_pkg::MSR_AW-1:0]  msrAddr,
    input  wire logic [63:0]                  msrWdata,
    output logic      [63:0]                  msrRdata,
    output logic                              msrDone,
    output logic                              generalProtectionFault,
    // privilege of the current cycle
    input  wire logic                         kernelLevel,
    // generic event bus
    input  wire logic [7:0]                   evtCode,
    input  wire logic [7:0]                   evtUmask,
    input  wire logic [3:0]                   evtCount,
    // retired load and demand request attributes
    input  wire logic                         loadRetired,
    input  wire logic                         loadLlcHit,
    input  wire logic                         loadL2Hit,
    input  wire logic                         loadLocked,
    input  wire logic                         demandReq,
    input  wire logic                         demandFromPrefetcher,
    input  wire logic [3:0]                   demandOutstanding,
    // call and abort sources
    input  wire logic                         callValid,
    input  wire logic [pecf_pkg::IP_W-1:0]    callIp,
    input  wire logic [3:0]                   callLen,
    input  wire logic [pecf_pkg::IP_W-1:0]    callTarget,
    input  wire logic                         abortValid,
    input  wire logic [pecf_pkg::IP_W-1:0]    abortIp,
    input  wire logic [pecf_pkg::IP_W-1:0]    abortHandler,
    // branch record stack push
    output logic                              recPush,
    output logic      [pecf_pkg::IP_W-1:0]    recFrom,
    output logic      [pecf_pkg::IP_W-1:0]    recTo
);
    import pecf_pkg::*;

    logic [63:0]      evtSel_r [NUM_CTR];
    logic [63:0]      evtSel_nxt [NUM_CTR];
    logic [CTR_W-1:0] ctr_r [NUM_CTR];
    logic [CTR_W-1:0] ctr_nxt [NUM_CTR];
    logic [3:0]       uncoreUnitCount_r;
    logic [63:0]      msrRdata_r;
    logic [63:0]      msrRdata_nxt;
    logic             msrDone_r;
    logic             msrDone_nxt;
    logic             fault_r;
    logic             fault_nxt;
    logic             recPush_r;
    logic             recPush_nxt;
    logic [IP_W-1:0]  recFrom_r;
    logic [IP_W-1:0]  recFrom_nxt;
    logic [IP_W-1:0]  recTo_r;
    logic [IP_W-1:0]  recTo_nxt;

    // register address decode
    logic        hitSel;
    logic        hitCtr;
    logic        hitUncCfg;
    logic        hitUncMon;
    logic [2:0]  selIdx;
    logic [2:0]  ctrIdx;
    logic [7:0]  uncUnit;
    logic        uncMissing;

    assign hitSel     = (msrAddr >= EVTSEL_BASE) && (msrAddr <= EVTSEL_LAST);
    assign hitCtr     = (msrAddr >= CTR_BASE) && (msrAddr <= CTR_LAST);
    assign hitUncCfg  = (msrAddr == UNC_CFG_ADDR);
    assign hitUncMon  = (msrAddr >= UNC_MON_BASE) && (msrAddr <= UNC_MON_LAST);
    assign selIdx     = 3'(msrAddr - EVTSEL_BASE);
    assign ctrIdx     = 3'(msrAddr - CTR_BASE);
    assign uncUnit    = 8'((msrAddr - UNC_MON_BASE) >> UNC_STRIDE_LSB);
    assign uncMissing = hitUncMon && (uncUnit >= {4'h0, uncoreUnitCount_r});

    // decoded load and demand occurrences
    logic llcHitOcc;
    logic llcMissOcc;
    logic l2HitOcc;
    logic demandOcc;

    assign llcHitOcc  = loadRetired && loadLlcHit;
    assign llcMissOcc = loadRetired && !loadLlcHit && !loadL2Hit;
    // locked loads count like any other second-level hit
    assign l2HitOcc   = loadRetired && loadL2Hit;
    assign demandOcc  = demandReq && !demandFromPrefetcher;

    // register access answer
    always_comb begin
        msrDone_nxt  = msrReq;
        fault_nxt    = 1'b0;
        msrRdata_nxt = 64'h0000_0000_0000_0000;
        if (msrReq) begin
            if (hitSel) begin
                msrRdata_nxt = evtSel_r[selIdx];
            end else if (hitCtr) begin
                msrRdata_nxt = {{(64-CTR_W){1'b0}}, ctr_r[ctrIdx]};
            end else if (hitUncCfg) begin
                msrRdata_nxt = {60'h0, uncoreUnitCount_r};
                fault_nxt    = msrWrite;
            end else if (hitUncMon) begin
                fault_nxt    = uncMissing;
            end else begin
                fault_nxt    = 1'b1;
            end
        end
    end

    // per-counter select storage, filter and increment
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CTR; gi++) begin : g_ctr
            logic [7:0] selCode;
            logic [7:0] selUmask;
            logic [7:0] count_threshold;
            logic       invert_flag;
            logic       privOk;
            logic       match;
            logic [3:0] occ;
            logic       over;
            logic       wrSel;
            logic       wrCtr;

            assign selCode  = evtSel_r[gi][SEL_EVT_LSB +: 8];
            assign selUmask = evtSel_r[gi][SEL_UMASK_LSB +: 8];
            assign count_threshold    = evtSel_r[gi][SEL_COUNT_THRESHOLD_LSB +: 8];
            assign invert_flag      = evtSel_r[gi][SEL_INV_BIT];
            assign privOk   = (kernelLevel && evtSel_r[gi][SEL_OS_BIT])
                           || (!kernelLevel && evtSel_r[gi][SEL_USR_BIT]);
            assign wrSel    = msrReq && msrWrite && hitSel && (selIdx == 3'(gi));
            assign wrCtr    = msrReq && msrWrite && hitCtr && (ctrIdx == 3'(gi));

            always_comb begin
                match = 1'b0;
                occ   = 4'h0;
                if (selCode == EVT_LOAD_RET && selUmask == UM_LLC_HIT) begin
                    occ = {3'h0, llcHitOcc};
                end else if (selCode == EVT_LOAD_RET && selUmask == UM_LLC_MISS) begin
                    occ = {3'h0, llcMissOcc};
                end else if (selCode == EVT_LOAD_RET && selUmask == UM_L2_HIT) begin
                    occ = {3'h0, l2HitOcc};
                end else if (selCode == EVT_DEMAND_REQ && selUmask == UM_DEMAND) begin
                    occ = {3'h0, demandOcc};
                end else if (selCode == EVT_DEMAND_OUT && selUmask == UM_DEMAND) begin
                    occ = demandFromPrefetcher ? 4'h0 : demandOutstanding;
                end else if (selCode == evtCode && selUmask == evtUmask) begin
                    occ = evtCount;
                end
                match = (occ != 4'h0);
                over  = ({4'h0, occ} >= count_threshold);
            end

            always_comb begin
                evtSel_nxt[gi] = wrSel ? msrWdata : evtSel_r[gi];
                ctr_nxt[gi]    = ctr_r[gi];
                if (wrCtr) begin
                    ctr_nxt[gi] = msrWdata[CTR_W-1:0];
                end else if (evtSel_r[gi][SEL_EN_BIT] && privOk) begin
                    if (count_threshold != 8'h00) begin
                        // threshold mode counts cycles; invert counts cycles below threshold, even with no event
                        if (over ^ invert_flag) begin
                            ctr_nxt[gi] = ctr_r[gi] + CTR_W'(1);
                        end
                    end else if (match) begin
                        ctr_nxt[gi] = ctr_r[gi] + CTR_W'(occ);
                    end
                end
            end

            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    evtSel_r[gi] <= SEL_RESET;
                    ctr_r[gi]    <= '0;
                end else begin
                    evtSel_r[gi] <= evtSel_nxt[gi];
                    ctr_r[gi]    <= ctr_nxt[gi];
                end
            end
        end
    endgenerate

    // branch record source selection
    logic [IP_W-1:0] nextIp;
    logic            zeroLenCall;

    assign nextIp      = callIp + IP_W'(callLen);
    assign zeroLenCall = (callTarget == nextIp);

    always_comb begin
        recPush_nxt = 1'b0;
        recFrom_nxt = recFrom_r;
        recTo_nxt   = recTo_r;
        if (abortValid) begin
            // abort inside a string op reports the aborting instruction itself
            recPush_nxt = 1'b1;
            recFrom_nxt = abortIp;
            recTo_nxt   = abortHandler;
        end else if (callValid && !zeroLenCall) begin
            recPush_nxt = 1'b1;
            recFrom_nxt = callIp;
            recTo_nxt   = callTarget;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            uncoreUnitCount_r <= UNC_UNITS_DEF;
            msrRdata_r        <= 64'h0000_0000_0000_0000;
            msrDone_r         <= 1'b0;
            fault_r           <= 1'b0;
            recPush_r         <= 1'b0;
            recFrom_r         <= '0;
            recTo_r           <= '0;
        end else begin
            uncoreUnitCount_r <= uncoreUnitCount_r;
            msrRdata_r        <= msrRdata_nxt;
            msrDone_r         <= msrDone_nxt;
            fault_r           <= fault_nxt;
            recPush_r         <= recPush_nxt;
            recFrom_r         <= recFrom_nxt;
            recTo_r           <= recTo_nxt;
        end
    end

    assign msrRdata               = msrRdata_r;
    assign msrDone                = msrDone_r;
    assign generalProtectionFault = fault_r;
    assign recPush                = recPush_r;
    assign recFrom                = recFrom_r;
    assign recTo                  = recTo_r;
endmodule

`default_nettype wire

/* File: tb/pecf_chk.sv */
// pecf_chk: port assertions for the counter filter block.
// assumes it is bound onto pecf_counter_filter.
`timescale 1ns/1ps
`default_nettype none
module pecf_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // register port
    input wire logic        msrReq,
    input wire logic        msrWrite,
    input wire logic [31:0] msrAddr,
    input wire logic [63:0] msrRdata,
    input wire logic        msrDone,
    input wire logic        generalProtectionFault,
    // records
    input wire logic        callValid,
    input wire logic [47:0] callIp,
    input wire logic [3:0]  callLen,
    input wire logic [47:0] callTarget,
    input wire logic        abortValid,
    input wire logic [47:0] abortIp,
    input wire logic        recPush,
    input wire logic [47:0] recFrom,
    input wire logic [47:0] recTo
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire zeroCall = callTarget == callIp + {44'h0, callLen};
    a_done_after_req: assert property (msrReq |=> msrDone) else $error("no done");
    a_no_stray_done: assert property (!msrReq |=> !msrDone) else $error("stray done");
    a_sel_no_fault: assert property (msrReq && msrAddr inside {[32'h186:32'h18D]}
        |=> !generalProtectionFault) else $error("select faulted");
    a_fault_cfg_wr: assert property (msrReq && msrWrite && msrAddr == 32'h396
        |=> generalProtectionFault) else $error("config write ok");
    a_fault_bad_unit: assert property (msrReq && msrAddr inside {[32'h740:32'h7FF]}
        |=> generalProtectionFault && msrDone) else $error("missing unit ok");
    a_unit_count_rd: assert property (msrReq && !msrWrite && msrAddr == 32'h396
        |=> msrRdata[3:0] == 4'h4 && !generalProtectionFault) else $error("unit count");
    a_abort_record: assert property (abortValid
        |=> recPush && recFrom == $past(abortIp)) else $error("abort source");
    a_zero_call_drop: assert property (callValid && !abortValid && zeroCall
        |=> !recPush) else $error("zero call pushed");
    a_call_record: assert property (callValid && !abortValid && !zeroCall
        |=> recPush && recTo == $past(callTarget)) else $error("call lost");
endmodule
bind pecf_counter_filter pecf_chk chk (.*);
`default_nettype wire

/* File: tb/pecf_evt_src.sv */
// pecf_evt_src: pipeline load and demand request source.
// assumes kind and outs come from the bench at rising edges.
`timescale 1ns/1ps
`default_nettype none
module pecf_evt_src (
    // command: 1 llc hit, 2 miss, 3 locked l2 hit, 4 demand, 5 prefetch
    input  wire logic [2:0] kind,
    input  wire logic [3:0] outs,
    // load and demand attributes
    output logic            loadRetired,
    output logic            loadLlcHit,
    output logic            loadL2Hit,
    output logic            loadLocked,
    output logic            demandReq,
    output logic            demandFromPrefetcher,
    output logic [3:0]      demandOutstanding
);
    always_comb begin
        loadRetired          = kind inside {3'h1, 3'h2, 3'h3};
        loadLlcHit           = kind == 3'h1;
        loadL2Hit            = kind == 3'h3;
        loadLocked           = kind == 3'h3;
        demandReq            = kind inside {3'h4, 3'h5};
        demandFromPrefetcher = kind == 3'h5;
        demandOutstanding    = demandReq ? outs : 4'h0;
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: random and corner checks of the counter filter block.
// assumes pecf_chk is bound and pecf_evt_src feeds load events.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock, resetn, msrReq, msrWrite, msrDone, generalProtectionFault;
    logic [31:0] msrAddr;
    logic [63:0] msrWdata, msrRdata, rd, expCnt[8];
    logic        kernelLevel, loadRetired, loadLlcHit, loadL2Hit, loadLocked;
    logic        demandReq, demandFromPrefetcher, callValid, abortValid, recPush, gp;
    logic [7:0]  evtCode, evtUmask;
    logic [3:0]  evtCount, demandOutstanding, callLen, outs;
    logic [2:0]  kind;
    logic [47:0] callIp, callTarget, abortIp, abortHandler, recFrom, recTo;
    logic [31:0] r;
    int          nMismatch, checksDone, occ;
    logic [63:0] sel[8] = '{64'h0043_40D1, 64'h0041_20D1, 64'h0043_02D1, 64'h0043_01B0,
                            64'h0043_0160, 64'h0042_0111, 64'h0243_0111, 64'h02C1_0111};

    pecf_counter_filter uut (.*);
    pecf_evt_src        src (.*);

    initial begin
        clock = 0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #20000;
        nMismatch++;
        close_out();
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int inc(input logic [63:0] s, input int o, input logic k);
        if (!s[22] || !((s[17] && k) || (s[16] && !k))) return 0;
        if (s[31:24] == 8'h0) return o;
        return ((o >= s[31:24]) ^ s[23]) ? 1 : 0;
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, s);
        checksDone++;
        if (s !== e) begin
            nMismatch++;
            $display("[ERR] %s exp %0h got %0h", nm, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
        @(posedge clock);
        msrReq <= 1'b1; msrWrite <= w; msrAddr <= a; msrWdata <= d;
        @(posedge clock);
        msrReq <= 1'b0;
        #1;
        rd = msrRdata;
        gp = generalProtectionFault;
    endtask
    task automatic rec(input logic cv, av, input logic [47:0] t);
        @(posedge clock);
        callValid <= cv; abortValid <= av; callTarget <= t;
        @(posedge clock);
        callValid <= 1'b0; abortValid <= 1'b0;
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        // kernel level keeps the user-only inverted threshold counter idle
        {msrReq, msrWrite, kernelLevel, callValid, abortValid} = 5'h04;
        msrAddr = 0; msrWdata = 0; kind = 0; outs = 0; evtCode = 0; evtUmask = 8'h01;
        evtCount = 0; callIp = 48'h1000; callLen = 4'h5; callTarget = 0;
        abortIp = 0; abortHandler = 48'h3000; r = 32'hB596;
        expCnt = '{default: 64'h0};
        resetn = 0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        for (int n = 0; n < 8; n++) acc(1'b1, 32'h186 + n, sel[n]);
        for (int n = 0; n < 8; n++) begin
            acc(1'b0, 32'h186 + n, 64'h0);
            chk("sel", sel[n], rd);
        end
        repeat (600) begin
            @(posedge clock);
            r = lfsr(r);
            kind <= r[2:0]; kernelLevel <= r[3]; outs <= r[7:4];
            evtCode <= r[8] ? 8'h11 : 8'h22; evtCount <= r[12:9];
            for (int n = 0; n < 8; n++) begin
                if (n == 4) occ = (r[2:0] == 3'h4) ? r[7:4] : 0;
                else if (n < 4) occ = (r[2:0] == n + 1);
                else occ = r[8] ? r[12:9] : 0;
                expCnt[n] += inc(sel[n], occ, r[3]);
            end
        end
        @(posedge clock);
        kind <= 3'h0; evtCount <= 4'h0;
        kernelLevel <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            acc(1'b0, 32'hC1 + n, 64'h0);
            chk("ctr", expCnt[n], rd);
        end
        acc(1'b0, 32'h396, 64'h0);
        chk("units", 4'h4, rd[3:0]);
        acc(1'b1, 32'h396, 64'h0);
        chk("cfgwr", 1'b1, gp);
        acc(1'b1, 32'h123, 64'h0);
        chk("unmap", 1'b1, gp);
        for (int u = 0; u < 8; u++) begin
            acc(1'b0, 32'h700 + u * 16, 64'h0);
            chk("unit", u >= 4, gp);
        end
        abortIp <= {16'h0, r};
        rec(1'b1, 1'b0, 48'h1005);
        chk("zcall", 1'b0, recPush);
        rec(1'b1, 1'b0, 48'h1006);
        chk("call", {1'b1, 48'h1006}, {recPush, recTo});
        rec(1'b1, 1'b1, 48'h1006);
        chk("abort", {1'b1, 16'h0, r}, {recPush, recFrom});
        close_out();
    end
endmodule
`default_nettype wire
